/* File: dv/multipipe_rx_addressing_timing_test.sv */
// Bench for the multi-pipe receive and timing block with a peer model.
// Assumes the peer model and the checker are compiled before it.
`timescale 1ns/1ps
module multipipe_rx_addressing_timing_test;
    logic        sys_clk = 1'b0, reset = 1'b1, ce_pin = 1'b1, stall = 1'b0;
    logic        primary_receiver = 1'b1, auto_ack_enable = 1'b1;
    logic        crc_enable = 1'b0, crc_two_bytes = 1'b0, air_rate_2m = 1'b0;
    logic        cfg_load = 1'b0, rd_ready = 1'b0, clear_rx_rdy = 1'b0;
    logic        clear_tx_snt = 1'b0, clear_max_rt = 1'b0;
    logic [1:0]  addr_width = 2'h1;
    logic [3:0]  retransmit_delay = 4'h1, retransmit_limit = 4'h1;
    logic [5:0]  payload_len = 6'h02, pipe_enable_bits = 6'h3F;
    logic [31:0] pipe_receive_address = 32'h0;
    logic [39:0] pipe_zero_receive_address = 40'h0, pipe_low_bytes = 40'h0;
    logic [39:0] tx_target_address = 40'h0;
    wire         rx_sync, rx_byte_valid, rx_pkt_end, rx_crc_ok, rx_no_ack;
    wire         rx_byte_ready, radio_tx_on, radio_rx_on, crc_active;
    wire         rd_valid, rx_data_ready_flag, tx_data_sent_flag;
    wire         max_retry_flag, irq_n;
    wire [7:0]   rx_byte, rd_data;
    wire [2:0]   rd_pipe;
    wire [5:0]   pipe_enable_state;
    wire [39:0]  air_dest_address;
    integer      seed = 32'h1A62E307;
    int          n_mismatch = 0, n_compared = 0, cyc = 0, k, p;
    logic [10:0] exp_q[$];

    multipipe_rx_addressing_timing u_dut (.*);
    peer_radio u_peer (.*);

    initial forever #20 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [39:0] exp,
                         input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 98000) begin
            n_mismatch++;
            finish_test();
        end
    end

    always @(negedge sys_clk) rd_ready <= !stall && ($random(seed) % 2 != 0);

    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            check("rd", exp_q.size() > 0 ? exp_q.pop_front() : 11'h7FF,
                  {rd_pipe, rd_data});
        end
    end

    function automatic logic [23:0] pipe_addr(input int n);
        if (n == 0) begin
            return pipe_zero_receive_address[23:0];
        end
        return {pipe_receive_address[15:0], pipe_low_bytes[8*n+:8]};
    endfunction

    task automatic wait_tx(input logic lv, input int lim);
        for (k = 0; k < lim && radio_tx_on !== lv; k++) @(negedge sys_clk);
    endtask

    task automatic load_en(input logic [5:0] v);
        pipe_enable_bits = v;
        cfg_load = 1'b1;
        @(negedge sys_clk);
        cfg_load = 1'b0;
        @(negedge sys_clk);
        check("en", v, pipe_enable_state);
    endtask

    task automatic rx_one(input int n, input logic no_ack, input logic on,
                          input logic mid, input int len);
        logic [255:0] pay;
        int i;
        payload_len = len[5:0];
        for (i = 0; i < 8; i++) pay[32*i+:32] = $random(seed);
        for (i = 0; i < len && on; i++) exp_q.push_back({n[2:0], pay[8*i+:8]});
        u_peer.send_frame(pipe_addr(n), len, pay, no_ack, mid);
        check("dr", on, rx_data_ready_flag);
        check("irq", !on, irq_n);
        clear_rx_rdy = 1'b1;
        @(negedge sys_clk);
        clear_rx_rdy = 1'b0;
        wait_tx(1'b1, 3400);
        check("ack", on && !no_ack, radio_tx_on);
        if (radio_tx_on === 1'b1) begin
            check("dest", pipe_addr(n), air_dest_address[23:0]);
            wait_tx(1'b0, 4000);
        end
    endtask

    task automatic ce_pulse();
        ce_pin = 1'b1;
        repeat (250) @(negedge sys_clk);
        ce_pin = 1'b0;
        wait_tx(1'b1, 4000);
    endtask

    initial begin
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check("en", 6'h03, pipe_enable_state);
        check("crc", 1'b1, crc_active);
        pipe_zero_receive_address = {$random(seed), 8'h0A};
        pipe_receive_address = $random(seed);
        for (p = 1; p < 6; p++) pipe_low_bytes[8*p+:8] = {p[3:0], 4'h5};
        load_en(6'h3F);
        for (p = 0; p < 6; p++) rx_one(p, p[0], 1'b1, 1'b0, 2);
        load_en(6'h3D);
        rx_one(1, 1'b0, 1'b0, 1'b0, 2);
        rx_one(2, 1'b1, 1'b1, 1'b1, 3);
        stall = 1'b1;
        fork
            rx_one(3, 1'b1, 1'b1, 1'b0, 20);
            begin
                for (p = 0; p < 400 && rx_byte_ready !== 1'b0; p++) begin
                    @(negedge sys_clk);
                end
                check("full", 1'b0, rx_byte_ready);
                stall = 1'b0;
            end
        join
        for (k = 0; k < 200 && exp_q.size() > 0; k++) @(negedge sys_clk);
        check("drain", 0, exp_q.size());
        ce_pin = 1'b0;
        primary_receiver = 1'b0;
        payload_len = 6'h02;
        repeat (4) @(negedge sys_clk);
        tx_target_address = pipe_zero_receive_address;
        ce_pulse();
        check("settle", 1'b1, k >= 2950 && k <= 3070);
        check("txdest", pipe_zero_receive_address, air_dest_address);
        wait_tx(1'b0, 3000);
        check("toa", 1'b1, k >= 1600 && k <= 1650);
        @(negedge sys_clk);
        check("rxon", 1'b1, radio_rx_on);
        payload_len = 6'h00;
        u_peer.send_frame(pipe_addr(0), 0, 256'h0, 1'b0, 1'b0);
        check("ds", 1'b1, tx_data_sent_flag);
        check("irq", 1'b0, irq_n);
        clear_tx_snt = 1'b1;
        @(negedge sys_clk);
        clear_tx_snt = 1'b0;
        air_rate_2m = 1'b1;
        crc_two_bytes = 1'b1;
        retransmit_delay = 4'h2;
        ce_pulse();
        wait_tx(1'b0, 3000);
        check("toa2m", 1'b1, k >= 700 && k <= 750);
        wait_tx(1'b1, 24000);
        check("retry", 1'b1, k >= 21950 && k <= 22050);
        wait_tx(1'b0, 3000);
        for (k = 0; k < 8000 && max_retry_flag !== 1'b1; k++) begin
            @(negedge sys_clk);
        end
        check("maxrt", 1'b1, max_retry_flag);
        clear_max_rt = 1'b1;
        auto_ack_enable = 1'b0;
        @(negedge sys_clk);
        clear_max_rt = 1'b0;
        check("irq", 1'b1, irq_n);
        check("crc", 1'b0, crc_active);
        finish_test();
    end
endmodule

/* File: dv/peer_radio.sv */
// Peer radio model driving the demodulated receive stream.
// Assumes the bench calls send_frame; three address bytes per frame.
`timescale 1ns/1ps
module peer_radio (
    input  wire        sys_clk,
    input  wire        rx_byte_ready,
    output logic       rx_sync,
    output logic [7:0] rx_byte,
    output logic       rx_byte_valid,
    output logic       rx_pkt_end,
    output logic       rx_crc_ok,
    output logic       rx_no_ack
);
    initial begin
        rx_sync = 1'b0;
        rx_byte = 8'h5A;
        rx_byte_valid = 1'b0;
        rx_pkt_end = 1'b0;
        rx_crc_ok = 1'b0;
        rx_no_ack = 1'b1;
    end
    // Outside a frame the byte lines carry nothing, so they keep changing.
    always @(posedge sys_clk) begin
        if (rx_byte_valid !== 1'b1) begin
            rx_byte <= ~rx_byte;
        end
    end
    task automatic send_frame(input logic [23:0] addr, input int len,
                              input logic [255:0] pay, input logic no_ack,
                              input logic mid);
        int i;
        @(negedge sys_clk);
        rx_sync = 1'b1;
        @(negedge sys_clk);
        rx_sync = 1'b0;
        rx_byte_valid = 1'b1;
        for (i = 0; i < 3; i++) begin
            rx_byte = addr[8*i+:8];
            @(negedge sys_clk);
        end
        rx_byte_valid = 1'b0;
        @(negedge sys_clk);
        for (i = 0; i < len; i++) begin
            rx_byte = pay[8*i+:8];
            rx_byte_valid = 1'b1;
            rx_sync = mid && i == 1;
            do @(posedge sys_clk); while (rx_byte_ready !== 1'b1);
            @(negedge sys_clk);
            rx_sync = 1'b0;
        end
        rx_byte_valid = 1'b0;
        rx_pkt_end = 1'b1;
        rx_crc_ok = 1'b1;
        rx_no_ack = no_ack;
        @(negedge sys_clk);
        rx_pkt_end = 1'b0;
        rx_crc_ok = 1'b0;
        rx_no_ack = ~no_ack;
    endtask
endmodule

/* File: dv/pipe_timing_props.sv */
// Port assertions for the multi-pipe receive and timing block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
module pipe_timing_props (
    input wire       sys_clk,
    input wire       reset,
    input wire       cfg_load,
    input wire       auto_ack_enable,
    input wire       crc_enable,
    input wire       rx_pkt_end,
    input wire       rd_ready,
    input wire       clear_rx_rdy,
    input wire       clear_tx_snt,
    input wire       radio_tx_on,
    input wire       radio_rx_on,
    input wire       crc_active,
    input wire       rd_valid,
    input wire       rx_data_ready_flag,
    input wire       tx_data_sent_flag,
    input wire       max_retry_flag,
    input wire       irq_n,
    input wire [5:0] pipe_enable_bits,
    input wire [5:0] pipe_enable_state,
    input wire [7:0] rd_data,
    input wire [2:0] rd_pipe
);
    logic [11:0] off_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Counts cycles with the transmitter off, saturating.
    always @(posedge sys_clk) begin
        if (reset || radio_tx_on) begin
            off_q <= 12'h000;
        end else if (off_q != 12'hFFF) begin
            off_q <= off_q + 12'h001;
        end
    end
    chk_crc_forced: assert property (
        crc_active == (crc_enable | auto_ack_enable)) else $error("crc");
    chk_irq_merge: assert property (
        irq_n == !(rx_data_ready_flag | tx_data_sent_flag | max_retry_flag))
        else $error("irq_n");
    chk_enable_load: assert property (
        cfg_load |=> pipe_enable_state == $past(pipe_enable_bits))
        else $error("pipe enable load");
    chk_tx_rx_excl: assert property (!(radio_tx_on && radio_rx_on))
        else $error("tx and rx both on");
    chk_dr_sticky: assert property (
        rx_data_ready_flag && !clear_rx_rdy |=> rx_data_ready_flag)
        else $error("data ready lost");
    chk_ds_sticky: assert property (
        tx_data_sent_flag && !clear_tx_snt |=> tx_data_sent_flag)
        else $error("data sent lost");
    chk_dr_cause: assert property (
        $rose(rx_data_ready_flag) |-> $past(rx_pkt_end))
        else $error("data ready without packet end");
    chk_rd_hold: assert property (
        rd_valid && !rd_ready |=> rd_valid && $stable({rd_pipe, rd_data}))
        else $error("read entry changed");
    chk_tx_settle: assert property (
        $rose(radio_tx_on) |-> off_q >= 12'hC80) else $error("settle");
endmodule

bind multipipe_rx_addressing_timing pipe_timing_props u_props (.*);

/* File: src/multipipe_rx_addressing_timing.v */
// Multi-pipe receive address matching and packet transaction sequencing.
// Assumes the demodulator on sys_clk delivers frames as sync, bytes and end.
//
// Operation
// - Six parallel receive pipes on one channel, each with its own decoder.
// - All enabled pipe addresses compared at once; only one pipe accepts.
// - After an address hit, other pipes are blocked until packet end.
// - CRC, address width and rate are shared by all pipes.
// - Auto acknowledge forces CRC on regardless of the CRC enable.
// - Each pipe has an enable bit; pipes 0 and 1 enabled after reset.
// - Each pipe address is held per pipe and is up to five bytes.
// - Pipe 0 has five own bytes; pipes 1 to 5 share upper four.
// - Acknowledge goes to the address of the pipe that took the packet.
// - Every pipe supports acknowledge and retransmit; six transmitters share.
// - Each autonomous sequence ends by asserting the interrupt pin.
// - Time on air is eight times packet bytes plus nine, over rate.
// - Transmit starts 130 us after chip activate and lasts time on air.
// - After transmitting, the transmitter switches to receive for the ack.
// - Transmitter sets data sent flag when the acknowledge arrives.
// - Receiver sets data ready flag after a valid packet is received.
// - No acknowledge is sent for packets flagged as not wanting one.
// - Retransmit delay is programmed in steps of 250 us.
`timescale 1ns/1ps
`include "rx_pipes_defs.vh"
module multipipe_rx_addressing_timing #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        ce_pin,
    input  wire        primary_receiver,
    input  wire        auto_ack_enable,
    input  wire        crc_enable,
    input  wire        crc_two_bytes,
    input  wire [1:0]  addr_width,
    input  wire        air_rate_2m,
    input  wire [5:0]  payload_len,
    input  wire [3:0]  retransmit_delay,
    input  wire [3:0]  retransmit_limit,
    input  wire        cfg_load,
    input  wire [5:0]  pipe_enable_bits,
    input  wire [39:0] pipe_zero_receive_address,
    input  wire [31:0] pipe_receive_address,
    input  wire [39:0] pipe_low_bytes,
    input  wire [39:0] tx_target_address,
    input  wire        rx_sync,
    input  wire [7:0]  rx_byte,
    input  wire        rx_byte_valid,
    output wire        rx_byte_ready,
    input  wire        rx_pkt_end,
    input  wire        rx_crc_ok,
    input  wire        rx_no_ack,
    output wire        radio_tx_on,
    output wire        radio_rx_on,
    output wire [39:0] air_dest_address,
    output wire        crc_active,
    output wire [7:0]  rd_data,
    output wire [2:0]  rd_pipe,
    output wire        rd_valid,
    input  wire        rd_ready,
    output wire        rx_data_ready_flag,
    output wire        tx_data_sent_flag,
    output wire        max_retry_flag,
    input  wire        clear_rx_rdy,
    input  wire        clear_tx_snt,
    input  wire        clear_max_rt,
    output wire        irq_n,
    output wire [5:0]  pipe_enable_state
);
    localparam [5:0] S_IDLE   = 6'h01;
    localparam [5:0] S_RX     = 6'h02;
    localparam [5:0] S_SETTLE = 6'h04;
    localparam [5:0] S_TX     = 6'h08;
    localparam [5:0] S_WAIT   = 6'h10;
    localparam [5:0] S_BACK   = 6'h20;

    reg  [5:0]  state_q;
    reg  [5:0]  pipe_en_q;
    reg         ce_meta_q;
    reg         ce_sync_q;
    reg         ce_prev_q;
    reg  [4:0]  div_q;
    reg         us_tick_q;
    reg  [11:0] timer_q;
    reg         ack_mode_q;
    reg  [3:0]  retry_cnt_q;
    reg  [39:0] dest_q;
    reg         rx_rdy_q;
    reg         tx_snt_q;
    reg         max_rt_q;
    reg  [39:0] addr_q;
    reg  [5:0]  byte_cnt_q;
    reg  [5:0]  pay_cnt_q;
    reg         in_frame_q;
    reg         addr_chk_q;
    reg         lock_q;
    reg  [2:0]  pipe_q;
    reg  [2:0]  hit_idx;
    reg         any_hit;
    reg  [39:0] width_mask;
    integer     i;

    wire [239:0] own_addr;
    wire [5:0]   pipe_hit;
    wire [5:0]   addr_bytes;
    wire [1:0]   crc_bytes;
    wire [6:0]   data_bytes;
    wire [6:0]   ack_bytes;
    wire [9:0]   data_bits;
    wire [9:0]   ack_bits;
    wire [10:0]  data_half;
    wire [10:0]  ack_half;
    wire [11:0]  toa_data_us;
    wire [11:0]  toa_ack_us;
    wire [15:0]  retry_prod;
    wire         timer_done;
    wire         ce_rise;
    wire         listening;
    wire         pay_phase;
    wire         fifo_in_ready;
    wire         fifo_wr;
    wire         pkt_done;
    wire         pkt_ok;
    wire         ack_good;
    wire         set_rx_rdy;
    wire         set_tx_snt;
    wire         retry_now;
    wire         set_max_rt;
    wire [10:0]  fifo_out;

    // Shared settings: one width, CRC and rate serve every pipe.
    assign crc_active = crc_enable | auto_ack_enable;
    assign addr_bytes = {4'h0, addr_width} + `ADDR_BYTES_BASE;
    assign crc_bytes  = crc_active ? (crc_two_bytes ? 2'h2 : 2'h1) : 2'h0;

    // Packet length in bytes: preamble, address, payload and CRC.
    assign data_bytes = `PREAMBLE_BYTES + {1'b0, addr_bytes}
                        + {1'b0, payload_len} + {5'h00, crc_bytes};
    assign ack_bytes  = `PREAMBLE_BYTES + {1'b0, addr_bytes}
                        + {5'h00, crc_bytes};
    assign data_bits  = {data_bytes, 3'b000} + `PCF_BITS;
    assign ack_bits   = {ack_bytes, 3'b000} + `PCF_BITS;
    assign data_half  = {1'b0, data_bits} + 11'h001;
    assign ack_half   = {1'b0, ack_bits} + 11'h001;
    // At 2 Mbps two bits take one microsecond tick, rounded up.
    assign toa_data_us = air_rate_2m ? {2'h0, data_half[10:1]}
                                     : {2'h0, data_bits};
    assign toa_ack_us  = air_rate_2m ? {2'h0, ack_half[10:1]}
                                     : {2'h0, ack_bits};
    assign retry_prod  = retransmit_delay * `RETRY_STEP_US;

    // Pipe 0 holds five own bytes; pipes 1-5 share the upper four.
    assign own_addr[39:0] = pipe_zero_receive_address;

    genvar g;
    generate
        for (g = 1; g < `PIPE_COUNT; g = g + 1) begin : g_addr
            assign own_addr[40*g +: 40] =
                {pipe_receive_address, pipe_low_bytes[8*g +: 8]};
        end
        for (g = 0; g < `PIPE_COUNT; g = g + 1) begin : g_pipe
            // Each pipe has its own decoder and its own enable.
            pipe_addr_match u_match (
                .enable     (pipe_en_q[g]),
                .width_mask (width_mask),
                .addr_in    (addr_q),
                .own_addr   (own_addr[40*g +: 40]),
                .hit        (pipe_hit[g])
            );
        end
    endgenerate

    always @* begin
        case (addr_width)
            2'h1:    width_mask = 40'h00_00FF_FFFF;
            2'h2:    width_mask = 40'h00_FFFF_FFFF;
            default: width_mask = 40'hFF_FFFF_FFFF;
        endcase
    end

    // All pipes are compared together; the lowest hit is the only taker.
    always @* begin
        hit_idx = 3'h0;
        any_hit = 1'b0;
        for (i = `PIPE_COUNT - 1; i >= 0; i = i - 1) begin
            if (pipe_hit[i]) begin
                hit_idx = i[2:0];
                any_hit = 1'b1;
            end
        end
    end

    assign timer_done = (timer_q == 12'h000);
    assign ce_rise    = ce_sync_q & ~ce_prev_q;
    assign listening  = state_q[1] | state_q[4];
    assign pay_phase  = lock_q & (byte_cnt_q >= addr_bytes)
                        & (pay_cnt_q < payload_len);
    assign rx_byte_ready = ~pay_phase | fifo_in_ready;
    assign fifo_wr    = pay_phase & rx_byte_valid & state_q[1];
    assign pkt_done   = rx_pkt_end & lock_q;
    assign pkt_ok     = rx_crc_ok | ~crc_active;
    assign ack_good   = pkt_ok & (pipe_q == 3'h0);

    assign set_rx_rdy = state_q[1] & pkt_done & pkt_ok;
    assign set_tx_snt = (state_q[3] & timer_done & ~ack_mode_q
                         & ~auto_ack_enable)
                        | (state_q[4] & pkt_done & ack_good);
    assign retry_now  = state_q[4] & ((pkt_done & ~ack_good)
                        | (timer_done & ~lock_q & ~rx_pkt_end));
    assign set_max_rt = retry_now & (retry_cnt_q == retransmit_limit);

    always @(posedge sys_clk) begin
        if (reset) begin
            ce_meta_q <= 1'b0;
            ce_sync_q <= 1'b0;
            ce_prev_q <= 1'b0;
            div_q     <= 5'h00;
            us_tick_q <= 1'b0;
            pipe_en_q <= `PIPE_EN_RESET;
        end else begin
            ce_meta_q <= ce_pin;
            ce_sync_q <= ce_meta_q;
            ce_prev_q <= ce_sync_q;
            us_tick_q <= (div_q == `US_TICK_LAST);
            div_q     <= (div_q == `US_TICK_LAST) ? 5'h00 : div_q + 5'h01;
            if (cfg_load) begin
                pipe_en_q <= pipe_enable_bits;
            end
        end
    end

    // Address assembly and pipe lock, low byte first.
    always @(posedge sys_clk) begin
        if (reset) begin
            addr_q     <= 40'h0;
            byte_cnt_q <= 6'h00;
            pay_cnt_q  <= 6'h00;
            in_frame_q <= 1'b0;
            addr_chk_q <= 1'b0;
            lock_q     <= 1'b0;
            pipe_q     <= 3'h0;
        end else begin
            addr_chk_q <= 1'b0;
            if (~listening | rx_pkt_end) begin
                in_frame_q <= 1'b0;
                lock_q     <= 1'b0;
            end else if (rx_sync & ~lock_q) begin
                // A locked pipe blocks every new frame until its end.
                in_frame_q <= 1'b1;
                byte_cnt_q <= 6'h00;
                pay_cnt_q  <= 6'h00;
                addr_q     <= 40'h0;
            end else if (addr_chk_q) begin
                lock_q     <= any_hit;
                in_frame_q <= any_hit;
                pipe_q     <= hit_idx;
            end else if (in_frame_q & rx_byte_valid & rx_byte_ready) begin
                if (byte_cnt_q < addr_bytes) begin
                    addr_q[8*byte_cnt_q[2:0] +: 8] <= rx_byte;
                    addr_chk_q <= (byte_cnt_q == addr_bytes - 6'h01);
                    byte_cnt_q <= byte_cnt_q + 6'h01;
                end else if (lock_q & (pay_cnt_q < payload_len)) begin
                    pay_cnt_q <= pay_cnt_q + 6'h01;
                end
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            state_q     <= S_IDLE;
            timer_q     <= 12'h000;
            ack_mode_q  <= 1'b0;
            retry_cnt_q <= 4'h0;
            dest_q      <= 40'h0;
            rx_rdy_q    <= 1'b0;
            tx_snt_q    <= 1'b0;
            max_rt_q    <= 1'b0;
        end else begin
            if (us_tick_q & ~timer_done) begin
                timer_q <= timer_q - 12'h001;
            end
            case (state_q)
                S_IDLE: begin
                    if (primary_receiver & ce_sync_q) begin
                        state_q <= S_RX;
                    end else if (~primary_receiver & ce_rise) begin
                        ack_mode_q  <= 1'b0;
                        retry_cnt_q <= 4'h0;
                        dest_q      <= tx_target_address;
                        timer_q     <= `SETTLE_TIME_US;
                        state_q     <= S_SETTLE;
                    end
                end
                S_RX: begin
                    if (pkt_done & pkt_ok & auto_ack_enable
                        & ~rx_no_ack) begin
                        ack_mode_q <= 1'b1;
                        dest_q     <= own_addr[40*pipe_q +: 40];
                        timer_q    <= `SETTLE_TIME_US;
                        state_q    <= S_SETTLE;
                    end else if (~ce_sync_q & ~lock_q) begin
                        state_q <= S_IDLE;
                    end
                end
                S_SETTLE: begin
                    if (timer_done) begin
                        timer_q <= ack_mode_q ? toa_ack_us
                                              : toa_data_us;
                        state_q <= S_TX;
                    end
                end
                S_TX: begin
                    if (timer_done & ack_mode_q) begin
                        state_q <= S_RX;
                    end else if (timer_done & auto_ack_enable) begin
                        timer_q <= `ACK_WAIT_US;
                        state_q <= S_WAIT;
                    end else if (timer_done) begin
                        state_q <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    if (pkt_done & ack_good) begin
                        state_q <= S_IDLE;
                    end else if (set_max_rt) begin
                        state_q <= S_IDLE;
                    end else if (retry_now) begin
                        retry_cnt_q <= retry_cnt_q + 4'h1;
                        timer_q     <= retry_prod[11:0];
                        state_q     <= S_BACK;
                    end
                end
                S_BACK: begin
                    if (timer_done) begin
                        timer_q <= `SETTLE_TIME_US;
                        state_q <= S_SETTLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
            // A set in the same cycle as a clear wins.
            rx_rdy_q <= set_rx_rdy | (rx_rdy_q & ~clear_rx_rdy);
            tx_snt_q <= set_tx_snt | (tx_snt_q & ~clear_tx_snt);
            max_rt_q <= set_max_rt | (max_rt_q & ~clear_max_rt);
        end
    end

    // Payload bytes are buffered with the accepting pipe number.
    sync_fifo #(
        .WIDTH (11),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (fifo_wr),
        .in_ready  (fifo_in_ready),
        .in_data   ({pipe_q, rx_byte}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (fifo_out)
    );

    assign rd_data            = fifo_out[7:0];
    assign rd_pipe            = fifo_out[10:8];
    assign radio_tx_on        = state_q[3];
    assign radio_rx_on        = state_q[1] | state_q[4];
    assign air_dest_address   = dest_q;
    assign rx_data_ready_flag = rx_rdy_q;
    assign tx_data_sent_flag  = tx_snt_q;
    assign max_retry_flag     = max_rt_q;
    assign irq_n              = ~(rx_rdy_q | tx_snt_q | max_rt_q);
    assign pipe_enable_state  = pipe_en_q;
endmodule

/* File: src/pipe_addr_match.v */
// One pipe's address decoder: compares an assembled address with its own.
// Assumes the caller supplies a byte mask for the shared address width.
`timescale 1ns/1ps
module pipe_addr_match (
    input  wire        enable,
    input  wire [39:0] width_mask,
    input  wire [39:0] addr_in,
    input  wire [39:0] own_addr,
    output wire        hit
);
    assign hit = enable & (((addr_in ^ own_addr) & width_mask) == 40'h0);
endmodule

/* File: src/rx_pipes_defs.vh */
// Shared constants for the multi-pipe receive and transaction timing block.
// Assumes a 25 MHz system clock; all times are kept in microseconds.
`ifndef RX_PIPES_DEFS_VH
`define RX_PIPES_DEFS_VH

`define PIPE_COUNT        6
`define PIPE_IDX_W        3
`define ADDR_BITS         40
`define PIPE_EN_RESET     6'h03
`define CLK_FREQ_MHZ      5'h19
`define US_TICK_LAST      (`CLK_FREQ_MHZ - 5'h01)
`define SETTLE_TIME_US    12'h082
`define CE_MIN_PULSE_US   12'h00A
`define RETRY_STEP_US     12'h0FA
`define ACK_WAIT_US       12'h0FA
`define PCF_BITS          10'h009
`define PREAMBLE_BYTES    7'h01
`define ADDR_BYTES_BASE   6'h02

`endif

/* File: src/sync_fifo.v */
// Synchronous FIFO in flip-flops with valid/ready handshakes on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sync_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             reset,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            do_wr;
    wire            do_rd;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_ptr_q];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_wr & ~do_rd) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (do_rd & ~do_wr) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
